// ### hw/bcs_charge_ctrl.sv
// charge-cycle state controller with indicators, event flags and register port
// What this block does
// - in constant-voltage mode, end-of-charge current flag completes the cycle
// - fast-charge time capped at one timeout unless the timeout gate is low
// - constant-voltage mode pulls charging indicator low, fault indicator released
// - a fault-free completed cycle moves to inhibit and watches battery voltage
// - in inhibit, battery below recharge threshold starts a new trickle cycle
// - inhibit releases both indicators high
// - timeout fault latches; only reset or standby (enable low or adapter absent) clears it
// - temperature fault resets without latch and restarts when temperature recovers
// - fault state pulls fault indicator low and releases charging indicator
// - standby while enable low or adapter absent; enable low stops charging
// - trickle needs fifteen consecutive periods above precondition level before constant current
// - trickle always limited to one eighth timeout, exceeding latches timeout fault
// - the timeout interval is 2^22 oscillator periods counted by the mode timer
// - enable rising edge starts a new charge cycle, as do other restart events
`default_nettype none

module bcs_charge_ctrl #(
    parameter int unsigned TIMEOUT_CYCLES = bcs_pkg::TIMEOUT_OSC_PERIODS
) (
    // clock and power-on reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // comparator flags and pins, asynchronous
    input  wire logic                         adapter_present_i,
    input  wire logic                         enable_i,
    input  wire logic                         timeout_gate_i,
    input  wire logic                         below_precondition_i,
    input  wire logic                         at_end_of_charge_i,
    input  wire logic                         below_recharge_i,
    input  wire logic                         temp_out_of_window_i,
    input  wire logic                         battery_removed_i,
    input  wire logic                         at_termination_voltage_i,
    // open-drain charging indicator
    input  wire logic                         charging_ind_i,
    output logic                              charging_ind_o,
    output logic                              charging_ind_oe_o,
    // open-drain fault indicator
    input  wire logic                         fault_ind_i,
    output logic                              fault_ind_o,
    output logic                              fault_ind_oe_o,
    // register port
    input  wire logic [bcs_pkg::ADDR_W-1:0]   addr_i,
    input  wire logic [bcs_pkg::DATA_W-1:0]   wdata_i,
    input  wire logic                         wr_i,
    input  wire logic                         rd_i,
    output logic      [bcs_pkg::DATA_W-1:0]   rdata_o,
    // interrupt
    output logic                              irq_o
);
    import bcs_pkg::*;

    // a timer of TMR_W bits cannot hold a larger interval
    if (TIMEOUT_CYCLES < 64 || TIMEOUT_CYCLES >= (1 << TMR_W))
    begin : g_bad_timeout
        $error("TIMEOUT_CYCLES out of range");
    end

    localparam logic [TMR_W-1:0] LIM_FAST = TMR_W'(TIMEOUT_CYCLES);
    localparam logic [TMR_W-1:0] LIM_TRK  = TMR_W'(TIMEOUT_CYCLES / TRICKLE_DIVISOR);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRECOND_PERIODS - 1);

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        bcs_state_t        state;
        logic              tmo_latch;
        logic [TMR_W-1:0]  timer;
        logic [PRE_W-1:0]  pre_cnt;
        logic [EV_W-1:0]   events;
        logic [EV_W-1:0]   mask;
        logic [DATA_W-1:0] rdata;
        logic              irq;
        logic              chg_oe;
        logic              flt_oe;
    } bcs_regs_t;

    bcs_regs_t q;
    bcs_regs_t d;

    logic [SYNC_W-1:0] raw;
    logic              powered;
    logic              temp_bad;
    logic [EV_W-1:0]   ev;

    // pins gathered into lanes for the synchroniser
    assign raw = {fault_ind_i, charging_ind_i, at_termination_voltage_i, battery_removed_i,
                  temp_out_of_window_i, below_recharge_i, at_end_of_charge_i,
                  below_precondition_i, timeout_gate_i, enable_i, adapter_present_i};

    // software decodes that both write and read paths need
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // next state of everything
    always_comb
    begin
        d        = q;
        ev       = '0;
        d.sync1  = raw;
        d.sync2  = q.sync1;
        powered  = q.sync2[SI_EN] && q.sync2[SI_ADAPTER];
        temp_bad = q.sync2[SI_TEMP] || q.sync2[SI_REMOVED];

        // mode timer saturates so a disabled limit never wraps into a fault
        if (q.timer != LIM_FAST)
        begin
            d.timer = q.timer + 23'h00_0001;
        end

        if (!powered)
        begin
            // standby wins over everything and forgets the latch
            d.state     = BCS_STANDBY;
            d.tmo_latch = 1'b0;
            d.timer     = '0;
            d.pre_cnt   = '0;
            if (q.state != BCS_STANDBY)
            begin
                ev[EV_STANDBY] = 1'b1;
            end
        end
        else
        begin
            unique case (q.state)
                BCS_STANDBY:
                begin
                    // enable rise or adapter attach restarts the cycle
                    d.state = BCS_TRICKLE;
                    d.timer = '0;
                end
                BCS_TRICKLE, BCS_CC, BCS_CV, BCS_INHIBIT:
                begin
                    if (temp_bad)
                    begin
                        d.state     = BCS_FAULT;
                        ev[EV_TEMP] = 1'b1;
                    end
                    else if (q.state == BCS_TRICKLE)
                    begin
                        if (q.timer >= LIM_TRK)
                        begin
                            // trickle cap ignores the timeout gate
                            d.state        = BCS_FAULT;
                            d.tmo_latch    = 1'b1;
                            ev[EV_TIMEOUT] = 1'b1;
                        end
                        else if (q.sync2[SI_PRECOND])
                        begin
                            d.pre_cnt = '0;
                        end
                        else if (q.pre_cnt == PRE_LAST)
                        begin
                            d.state   = BCS_CC;
                            d.timer   = '0;
                            d.pre_cnt = '0;
                        end
                        else
                        begin
                            d.pre_cnt = q.pre_cnt + 4'h1;
                        end
                    end
                    else if (q.state != BCS_INHIBIT && q.timer == LIM_FAST
                             && q.sync2[SI_TOGATE])
                    begin
                        // the timer runs on through constant current into constant voltage
                        d.state        = BCS_FAULT;
                        d.tmo_latch    = 1'b1;
                        ev[EV_TIMEOUT] = 1'b1;
                    end
                    else if (q.state == BCS_CC && q.sync2[SI_TERMV])
                    begin
                        d.state = BCS_CV;
                    end
                    else if (q.state == BCS_CV && q.sync2[SI_EOC])
                    begin
                        d.state     = BCS_INHIBIT;
                        ev[EV_DONE] = 1'b1;
                    end
                    else if (q.state == BCS_INHIBIT && q.sync2[SI_RECHG])
                    begin
                        d.state      = BCS_TRICKLE;
                        d.timer      = '0;
                        ev[EV_RECHG] = 1'b1;
                    end
                end
                BCS_FAULT:
                begin
                    // a latched timeout waits for standby; others recover by themselves
                    if (!q.tmo_latch && !temp_bad)
                    begin
                        d.state   = BCS_TRICKLE;
                        d.timer   = '0;
                        d.pre_cnt = '0;
                    end
                end
                default:
                begin
                    d.state = BCS_STANDBY;
                end
            endcase
        end

        // indicators follow the next state so that they stand with it
        d.chg_oe = (d.state == BCS_TRICKLE) || (d.state == BCS_CC)
                   || (d.state == BCS_CV);
        d.flt_oe = (d.state == BCS_FAULT);

        // sticky events: a set in the clearing cycle survives
        d.events = q.events;
        if (wr_i && hit(addr_i, OFS_EVENTS))
        begin
            d.events = q.events & ~wdata_i[EV_W-1:0];
        end
        d.events = d.events | ev;
        if (wr_i && hit(addr_i, OFS_MASK))
        begin
            d.mask = wdata_i[EV_W-1:0];
        end
        d.irq = |(d.events & d.mask);

        // read data stand only in the cycle after the strobe
        d.rdata = '0;
        if (rd_i)
        begin
            if (hit(addr_i, OFS_EVENTS))
            begin
                d.rdata[EV_W-1:0] = q.events;
            end
            else if (hit(addr_i, OFS_MASK))
            begin
                d.rdata[EV_W-1:0] = q.mask;
            end
            else if (hit(addr_i, OFS_STATE))
            begin
                d.rdata[2:0]          = q.state;
                d.rdata[ST_LATCH_BIT] = q.tmo_latch;
                d.rdata[ST_CHGPIN]    = q.sync2[SI_CHGPIN];
                d.rdata[ST_FLTPIN]    = q.sync2[SI_FLTPIN];
            end
        end
    end

    // one register bank; power-on reset gives standby with both pins released
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q        <= '0;
            q.state  <= BCS_STANDBY;
            q.mask   <= MASK_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // open-drain pins only ever pull low
    assign charging_ind_o    = 1'b0;
    assign fault_ind_o       = 1'b0;
    assign charging_ind_oe_o = q.chg_oe;
    assign fault_ind_oe_o    = q.flt_oe;
    assign rdata_o           = q.rdata;
    assign irq_o             = q.irq;

    // checks on the sequencing
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic s_pow;
    logic s_bad;
    assign s_pow = q.sync2[SI_EN] && q.sync2[SI_ADAPTER];
    assign s_bad = q.sync2[SI_TEMP] || q.sync2[SI_REMOVED];

    standby_priority_a: assert property (!s_pow |=> q.state == BCS_STANDBY
        && !q.tmo_latch && q.timer == '0 && !charging_ind_oe_o && !fault_ind_oe_o)
        else $error("standby not taken or not clean");
    cv_indicators_a: assert property (q.state == BCS_CV |-> charging_ind_oe_o
        && !fault_ind_oe_o)
        else $error("wrong indicators in constant voltage");
    eoc_to_inhibit_a: assert property (q.state == BCS_CV && s_pow && !s_bad
        && q.sync2[SI_EOC] && !(q.timer == LIM_FAST && q.sync2[SI_TOGATE])
        |=> q.state == BCS_INHIBIT && q.events[EV_DONE])
        else $error("end of charge did not reach inhibit");
    inhibit_release_a: assert property (q.state == BCS_INHIBIT |->
        !charging_ind_oe_o && !fault_ind_oe_o)
        else $error("indicator driven in inhibit");
    recharge_start_a: assert property (q.state == BCS_INHIBIT && s_pow && !s_bad
        && q.sync2[SI_RECHG] |=> q.state == BCS_TRICKLE && q.timer == '0)
        else $error("recharge did not restart trickle");
    fault_pins_a: assert property (q.state == BCS_FAULT |-> fault_ind_oe_o
        && !charging_ind_oe_o)
        else $error("wrong indicators in fault");
    latch_holds_a: assert property (q.state == BCS_FAULT && q.tmo_latch
        && s_pow |=> q.state == BCS_FAULT && q.tmo_latch)
        else $error("timeout latch released while powered");
    temp_recover_a: assert property (q.state == BCS_FAULT && !q.tmo_latch
        && s_pow && !s_bad |=> q.state == BCS_TRICKLE)
        else $error("no restart after temperature fault");
    fast_timeout_a: assert property ((q.state == BCS_CC || q.state == BCS_CV)
        && s_pow && !s_bad && q.timer == LIM_FAST && q.sync2[SI_TOGATE]
        |=> q.state == BCS_FAULT && q.tmo_latch)
        else $error("fast charge timeout missed");
    trickle_cap_a: assert property (q.state == BCS_TRICKLE && s_pow && !s_bad
        && q.timer >= LIM_TRK |=> q.state == BCS_FAULT && q.tmo_latch)
        else $error("trickle cap missed");
    precond_filter_a: assert property (q.state == BCS_TRICKLE ##1 q.state == BCS_CC
        |-> $past(q.pre_cnt) == PRE_LAST && $past(q.sync2[SI_PRECOND]) == 1'b0)
        else $error("left trickle before fifteen good periods");
    enable_rise_a: assert property ($rose(s_pow) |=> q.state == BCS_TRICKLE
        && q.timer == '0)
        else $error("enable rise did not start a cycle");
    irq_level_a: assert property (##1 irq_o == |(q.events & q.mask) || $past(wr_i))
        else $error("interrupt does not follow masked events");

    full_cycle_c: cover property (q.state == BCS_CV ##1 q.state == BCS_INHIBIT);
    timeout_c:    cover property (q.state == BCS_CC ##1 q.state == BCS_FAULT && q.tmo_latch);
    temp_c:       cover property (q.state == BCS_FAULT && !q.tmo_latch
                                  ##1 q.state == BCS_TRICKLE);
    recharge_c:   cover property (q.state == BCS_INHIBIT ##1 q.state == BCS_TRICKLE);

endmodule : bcs_charge_ctrl

`default_nettype wire

// ### hw/bcs_pkg.sv
// constants, state codes and register map of the charge state controller
`default_nettype none

package bcs_pkg;

    // timeout interval in oscillator periods and the trickle share of it
    localparam int unsigned TIMEOUT_OSC_PERIODS = 4194304;   // 2^22
    localparam int unsigned TRICKLE_DIVISOR     = 8;
    localparam int unsigned PRECOND_PERIODS     = 15;
    localparam int unsigned TMR_W               = 23;
    localparam int unsigned PRE_W               = 4;

    // synchroniser lanes
    localparam int unsigned SYNC_W     = 11;
    localparam int unsigned SI_ADAPTER = 0;
    localparam int unsigned SI_EN      = 1;
    localparam int unsigned SI_TOGATE  = 2;
    localparam int unsigned SI_PRECOND = 3;
    localparam int unsigned SI_EOC     = 4;
    localparam int unsigned SI_RECHG   = 5;
    localparam int unsigned SI_TEMP    = 6;
    localparam int unsigned SI_REMOVED = 7;
    localparam int unsigned SI_TERMV   = 8;
    localparam int unsigned SI_CHGPIN  = 9;
    localparam int unsigned SI_FLTPIN  = 10;

    // register map, byte addresses
    localparam int unsigned  ADDR_W      = 8;
    localparam int unsigned  DATA_W      = 32;
    localparam logic [7:0]   OFS_EVENTS  = 8'h00;
    localparam logic [7:0]   OFS_MASK    = 8'h04;
    localparam logic [7:0]   OFS_STATE   = 8'h08;
    localparam logic [4:0]   MASK_RESET  = 5'h00;

    // event bits of the status and mask registers
    localparam int unsigned EV_W       = 5;
    localparam int unsigned EV_DONE    = 0;
    localparam int unsigned EV_TIMEOUT = 1;
    localparam int unsigned EV_TEMP    = 2;
    localparam int unsigned EV_RECHG   = 3;
    localparam int unsigned EV_STANDBY = 4;

    // fields of the state register
    localparam int unsigned ST_LATCH_BIT = 3;
    localparam int unsigned ST_CHGPIN    = 4;
    localparam int unsigned ST_FLTPIN    = 5;

    typedef enum logic [2:0] {
        BCS_STANDBY = 3'b000,
        BCS_TRICKLE = 3'b001,
        BCS_CC      = 3'b010,
        BCS_CV      = 3'b011,
        BCS_INHIBIT = 3'b100,
        BCS_FAULT   = 3'b101
    } bcs_state_t;

endpackage : bcs_pkg

`default_nettype wire

// ### test/bcs_pack_model.sv
// behavioural battery pack, adapter, host enable and indicator pull-ups
`default_nettype none

module bcs_pack_model (
    // clock
    input  wire logic       clk_i,
    // flag levels wanted by the bench, in synchroniser lane order
    input  wire logic [8:0] cmd_i,
    // indicator pull-down enables from the controller
    input  wire logic       chg_oe_i,
    input  wire logic       flt_oe_i,
    // comparator flags and resolved pin levels
    output logic      [8:0] flag_o,
    output logic            chg_pin_o,
    output logic            flt_pin_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // comparators settle one oscillator period after the pack changes
    always_ff @(posedge clk_i)
    begin
        flag_o <= cmd_i;   // host stops charging by pulling enable low
    end

    // external pull-ups: a released pin reads high, never its last driven value
    assign chg_pin_o = chg_oe_i ? 1'b0 : 1'b1;
    assign flt_pin_o = flt_oe_i ? 1'b0 : 1'b1;

endmodule : bcs_pack_model
`default_nettype wire

// ### test/test_battery_charge_state_controller.sv
// self-checking bench for the charge state controller
`default_nettype none

module test_battery_charge_state_controller import bcs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        logic [8:0] c;
        int         n;
        bcs_state_t s;
        logic       cp;
        logic       fp;
    } bcs_row_t;

    logic        clk_i;
    logic        rst_i;
    logic [8:0]  cmd;
    logic [8:0]  flag;
    logic        chg_oe;
    logic        flt_oe;
    logic        chg_pin;
    logic        flt_pin;
    logic        chg_o;
    logic        flt_o;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd_s;
    logic [31:0] rdata;
    logic        irq;
    logic [31:0] d;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    // ordinary walk: flags (termv,removed,temp,rechg,eoc,pre,gate,en,adapter)
    bcs_row_t rows[12] = '{
        '{9'h00F, 5, BCS_TRICKLE, 1'b0, 1'b1}, '{9'h007, 10, BCS_TRICKLE, 1'b0, 1'b1},
        '{9'h007, 12, BCS_CC, 1'b0, 1'b1},     '{9'h107, 6, BCS_CV, 1'b0, 1'b1},
        '{9'h117, 6, BCS_INHIBIT, 1'b1, 1'b1}, '{9'h02F, 6, BCS_TRICKLE, 1'b0, 1'b1},
        '{9'h04F, 6, BCS_FAULT, 1'b1, 1'b0},   '{9'h00F, 6, BCS_TRICKLE, 1'b0, 1'b1},
        '{9'h08F, 6, BCS_FAULT, 1'b1, 1'b0},   '{9'h00F, 6, BCS_TRICKLE, 1'b0, 1'b1},
        '{9'h00D, 6, BCS_STANDBY, 1'b1, 1'b1}, '{9'h00F, 6, BCS_TRICKLE, 1'b0, 1'b1}};

    // small timeout keeps the run short: trickle cap 32, fast limit 256
    bcs_charge_ctrl #(.TIMEOUT_CYCLES(256)) dut (
        .clk_i(clk_i), .rst_i(rst_i),
        .adapter_present_i(flag[SI_ADAPTER]), .enable_i(flag[SI_EN]),
        .timeout_gate_i(flag[SI_TOGATE]), .below_precondition_i(flag[SI_PRECOND]),
        .at_end_of_charge_i(flag[SI_EOC]), .below_recharge_i(flag[SI_RECHG]),
        .temp_out_of_window_i(flag[SI_TEMP]), .battery_removed_i(flag[SI_REMOVED]),
        .at_termination_voltage_i(flag[SI_TERMV]),
        .charging_ind_i(chg_pin), .charging_ind_o(chg_o), .charging_ind_oe_o(chg_oe),
        .fault_ind_i(flt_pin), .fault_ind_o(flt_o), .fault_ind_oe_o(flt_oe),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd_s), .rdata_o(rdata),
        .irq_o(irq));

    bcs_pack_model pack (
        .clk_i(clk_i), .cmd_i(cmd), .chg_oe_i(chg_oe), .flt_oe_i(flt_oe),
        .flag_o(flag), .chg_pin_o(chg_pin), .flt_pin_o(flt_pin));

    // 50 MHz oscillator
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    // register write: one strobe cycle
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg

    // register read: data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_i);
        rd_s <= 1'b0;
        #1 q = rdata;
    endtask : rd

    // new pack conditions, then let them ripple through the synchroniser
    task automatic go(input logic [8:0] c, input int n);
        @(posedge clk_i);
        cmd <= c;
        repeat (n) @(posedge clk_i);
    endtask : go

    // a hang counts as a mismatch
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            stop_test();
        end
    end

    initial
    begin
        rst_i = 1'b1;
        cmd = 9'h000;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd_s = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("oe_reset", 32'h0000_0000, {30'h0, chg_oe, flt_oe});
        rd(OFS_MASK, d);
        chk("mask_reset", 32'h0000_0000, d);
        rd(OFS_STATE, d);
        chk("state_reset", 32'h0000_0030, d);
        foreach (rows[i])
        begin
            go(rows[i].c, rows[i].n);
            rd(OFS_STATE, d);
            chk("state", {29'h0, rows[i].s}, {29'h0, d[2:0]});
            chk("chg_pin", {31'h0, rows[i].cp}, {31'h0, chg_pin});
            chk("flt_pin", {31'h0, rows[i].fp}, {31'h0, flt_pin});
        end
        // trickle overrun with the gate low still latches a timeout
        go(9'h00B, 45);
        rd(OFS_STATE, d);
        chk("trickle_to", 32'h0000_000D, {28'h0, d[3:0]});
        chk("flt_pin_to", 32'h0000_0000, {31'h0, flt_pin});
        chk("od_value", 32'h0000_0000, {30'h0, chg_o, flt_o});
        go(9'h003, 30);
        rd(OFS_STATE, d);
        chk("latch_held", 32'h0000_000D, {28'h0, d[3:0]});
        // enable toggle releases the latch and restarts in trickle
        go(9'h001, 6);
        go(9'h007, 6);
        rd(OFS_STATE, d);
        chk("toggle", 32'h0000_0001, {28'h0, d[3:0]});
        go(9'h007, 200);
        rd(OFS_STATE, d);
        chk("cc_before_to", 32'h0000_0002, {28'h0, d[3:0]});
        go(9'h007, 80);
        rd(OFS_STATE, d);
        chk("fast_to", 32'h0000_000D, {28'h0, d[3:0]});
        // gate low: fast charge may run past the timeout
        go(9'h001, 6);
        go(9'h003, 320);
        rd(OFS_STATE, d);
        chk("gate_low", 32'h0000_0002, {28'h0, d[3:0]});
        go(9'h002, 6);
        rd(OFS_STATE, d);
        chk("no_adapter", 32'h0000_0030, d);
        // events, mask and interrupt
        rd(OFS_EVENTS, d);
        chk("events", 32'h0000_001F, d);
        chk("irq_masked", 32'h0000_0000, {31'h0, irq});
        wr_reg(OFS_MASK, 32'h0000_0002);
        rd(OFS_MASK, d);
        chk("mask", 32'h0000_0002, d);
        chk("irq_set", 32'h0000_0001, {31'h0, irq});
        wr_reg(OFS_EVENTS, 32'h0000_0002);
        rd(OFS_EVENTS, d);
        chk("events_w1c", 32'h0000_001D, d);
        chk("irq_clear", 32'h0000_0000, {31'h0, irq});
        rd(8'h0C, d);
        chk("unmapped", 32'h0000_0000, d);
        wr_reg(OFS_STATE, 32'hFFFF_FFFF);
        rd(OFS_STATE, d);
        chk("state_ro", 32'h0000_0030, d);
        @(posedge clk_i);
        #1 chk("rdata_idle", 32'h0000_0000, rdata);
        stop_test();
    end

endmodule : test_battery_charge_state_controller
`default_nettype wire
